// ===== pkg/fbd_pkg.sv
// Purpose: shared constants and types for the fsk baseband digital control block
// Assumes: registers sit behind a decoded 7-bit address / 8-bit data register port
// Notes: all counts are in ref_clk cycles; ref_clk stands in for the crystal clock
//
// Functional notes
// [RULE1] one up pulse per one, down per zero
// [RULE2] expect twice modulation index pulses per symbol
// [RULE3] mode: off, up only, down only, up-down
// [RULE4] length codes give 8, 16, 32, 64 symbols
// [RULE5] eight-bit two's complement result, host readable
// [RULE6] negative results only when down pulses counted
// [RULE7] counter wraps modulo 256, never saturates
// [RULE8] host raises crystal tune on positive offset
// [RULE9] host should prefer up-down counting mode
// [RULE10] synchronizer active in receive only when enabled
// [RULE11] one recovered clock cycle per received bit
// [RULE12] received bit changes at recovered clock rise
// [RULE13] host samples received bit on falling edge
// [RULE14] host sets synchronizer clock sixteen times bitrate
// [RULE15] clock = crystal / (k * 2^(7-s))
// [RULE16] one reference divider feeds all derived clocks
// [RULE17] synchronizer locks within 22 bits worst case
// [RULE18] three-bit power level, nonzero keeps amplifier on
// [RULE19] all-zero power level switches amplifier off
// [RULE20] bypass drops output, level still scales
// [RULE21] transmit uses divider set matching data bit
// [RULE22] data pin input in transmit, output receive
// [RULE23] transmit clock driven, data sampled on rise
// [RULE24] nonzero mode write clears and restarts measurement
// [RULE25] host writes fixed constant bits as printed

package fbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [6:0] FBD_MAIN_CONTROL = 7'h00;
  localparam logic [6:0] FBD_SIGNAL_FILTER_CONTROL = 7'h01;
  localparam logic [6:0] FBD_SYNC_CLOCK_SCALE = 7'h06;
  localparam logic [6:0] FBD_RATE_SCALE_AND_REF_DIVIDER = 7'h07;
  localparam logic [6:0] FBD_ERROR_ESTIMATOR_CONTROL = 7'h15;
  localparam logic [6:0] FBD_ERROR_ESTIMATOR_RESULT = 7'h16;

  localparam logic [7:0] FBD_REG_RESET = 8'h00;
  localparam logic [7:0] FBD_ESTIMATOR_CTRL_MASK = 8'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FBD_FRONT_AMP_BYPASS_BIT = 7;
  localparam int FBD_POWER_LSB = 4;
  localparam int FBD_SYNC_EN_BIT = 3;
  localparam int FBD_OP_MODE_LSB = 1;
  localparam int FBD_SIG_STRENGTH_BIT = 3;
  localparam int FBD_LOCK_DETECT_BIT = 2;
  localparam int FBD_PREFILTER_LSB = 0;
  localparam int FBD_RESYNC_SCALE_LSB = 1;
  localparam int FBD_RATE_SCALE_MSB_BIT = 0;
  localparam int FBD_RATE_SCALE_LOW_LSB = 6;
  localparam int FBD_REF_DIV_LSB = 0;
  localparam int FBD_EST_MODE_LSB = 0;
  localparam int FBD_EST_LENGTH_LSB = 2;

  // operating mode code that selects transmit
  localparam logic [1:0] FBD_OP_MODE_TX = 2'h2;
  localparam logic [2:0] FBD_POWER_OFF = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // clock divider and synchronizer figures
  localparam int FBD_DIV_WIDTH = 13;
  localparam int FBD_SCALE_TOP = 7;
  localparam logic [5:0] FBD_REF_DIV_MIN = 6'h01;
  localparam logic [3:0] FBD_PHASE_MID = 4'h8;
  localparam logic [3:0] FBD_PHASE_TOP = 4'hf;
  localparam logic [3:0] FBD_PHASE_ONE = 4'h1;
  localparam logic [3:0] FBD_PHASE_TWO = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // error estimator
  typedef enum logic [1:0] {
    FBD_EST_OFF = 2'b00,
    FBD_EST_UP = 2'b01,
    FBD_EST_DN = 2'b10,
    FBD_EST_UPDN = 2'b11
  } fbd_est_mode_type;

  typedef enum logic [0:0] {
    FBD_FEE_IDLE = 1'b0,
    FBD_FEE_RUN = 1'b1
  } fbd_fee_state_type;

  localparam logic [6:0] FBD_LEN_8 = 7'h08;
  localparam logic [6:0] FBD_LEN_16 = 7'h10;
  localparam logic [6:0] FBD_LEN_32 = 7'h20;
  localparam logic [6:0] FBD_LEN_64 = 7'h40;
  localparam logic [7:0] FBD_STEP_UP = 8'h01;
  localparam logic [7:0] FBD_STEP_DN = 8'hff;
  localparam logic [7:0] FBD_STEP_NONE = 8'h00;

endpackage : fbd_pkg

// ===== src/fbd_rate_div.sv
// Purpose: programmable tick generator, period k * 2^(7-s) ref_clk cycles
// Assumes: k of zero is treated as one so the divider never stalls
// Notes: tick marks the start of a period, half_tick its middle

`timescale 1ns/100ps
`default_nettype none

module fbd_rate_div
  import fbd_pkg::*;
(
  input wire logic ref_clk,        // crystal-rate clock
  input wire logic nrst,           // async reset, active low
  input wire logic run,            // counts only while high
  input wire logic [5:0] ref_div,  // shared reference divider k
  input wire logic [2:0] scale,    // power-of-two scale s
  output logic tick,               // one-cycle pulse per period
  output logic half_tick           // one-cycle pulse mid period
);

  logic [FBD_DIV_WIDTH-1:0] period;
  logic [FBD_DIV_WIDTH-1:0] cnt_q;
  logic [5:0] k_eff;

  // period = k * 2^(7-s) with k clamped to one
  always_comb begin
    k_eff = (ref_div == 6'h00) ? FBD_REF_DIV_MIN : ref_div;
    period = FBD_DIV_WIDTH'({7'h00, k_eff} << (3'(FBD_SCALE_TOP) - scale)); // RULE15
  end

  ////////////////////////////////////////////////////////////////////////////
  // free-running count, restarted when idle so the first tick is clean
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!run || (cnt_q >= period - FBD_DIV_WIDTH'(1))) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + FBD_DIV_WIDTH'(1);
    end
  end

  // registered strobes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      tick <= run && (cnt_q == '0);
      half_tick <= run && (period > FBD_DIV_WIDTH'(1)) && (cnt_q == (period >> 1));
    end
  end

  // each tick falls at a period start, one cycle after the count stood at zero
  chk_tick_spacing : assert property (@(posedge ref_clk) disable iff (!nrst) // RULE15
    tick && $stable(period) && $past(run) |-> $past(cnt_q) == '0)
    else $error("tick not at period start");

endmodule : fbd_rate_div

`default_nettype wire

// ===== src/fbd_core.sv
// Purpose: digital control of an fsk transceiver: estimator, synchronizer, transmit path
// Assumes: demodulator strobes and pin inputs are synchronous to ref_clk
// Notes: register port is the decoded side of the serial programming interface

`timescale 1ns/100ps
`default_nettype none

module fbd_core
  import fbd_pkg::*;
(
  input wire logic ref_clk,               // crystal-rate clock, 125 MHz
  input wire logic nrst,                  // async reset, active low
  input wire logic [6:0] reg_addr,        // register address
  input wire logic reg_wr,                // write strobe, one cycle
  input wire logic [7:0] reg_wdata,       // write data
  output logic [7:0] reg_rdata,           // read data, one cycle after address
  input wire logic demod_up,              // up pulse from demodulator
  input wire logic demod_dn,              // down pulse from demodulator
  input wire logic demod_bit,             // raw demodulated bit
  input wire logic amplifier_bypass,      // amplifier bypass request
  input wire logic data_io_pin_in,        // data pin level
  output logic data_io_pin_out,           // data pin drive value
  output logic data_io_pin_oe_n,          // data pin enable, low drives
  output logic data_clock_pin_out,        // data clock pin value
  output logic data_clock_pin_oe_n,       // data clock pin enable, low drives
  output logic tone_divider_set,          // 0 space set, 1 mark set
  output logic [2:0] output_power_level,  // amplifier level code
  output logic pa_enable,                 // amplifier on
  output logic pa_bypass,                 // amplifier bypassed
  output logic front_amp_bypass,          // front amplifier bypass
  output logic signal_strength_enable,    // rssi enable
  output logic lock_detect_enable,        // lock detect enable
  output logic [1:0] prefilter_cutoff,    // prefilter cutoff code
  output logic sync_locked                // synchronizer aligned
);

  logic [7:0] main_q, filter_q, sync_scale_q, rate_ref_q, est_ctrl_q, result_q;
  logic is_tx, sync_en;
  logic [5:0] ref_div;
  logic [2:0] resync_clock_scale, symbol_rate_clock_scale;
  fbd_est_mode_type estimator_mode_field;
  logic [1:0] estimator_length_field;
  logic rate_tick, rate_half, os_tick;
  logic [3:0] phase_q;
  logic bit_prev_q, bit_edge, bit_center, bit_clk_fall;
  fbd_fee_state_type fee_q;
  logic [7:0] cnt_q, cnt_d, step;
  logic [6:0] sym_q, sym_len;
  logic sym_end, est_start;

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  always_comb begin
    is_tx = (main_q[FBD_OP_MODE_LSB +: 2] == FBD_OP_MODE_TX);
    sync_en = main_q[FBD_SYNC_EN_BIT];
    ref_div = rate_ref_q[FBD_REF_DIV_LSB +: 6];
    resync_clock_scale = sync_scale_q[FBD_RESYNC_SCALE_LSB +: 3];
    symbol_rate_clock_scale = {sync_scale_q[FBD_RATE_SCALE_MSB_BIT],
                               rate_ref_q[FBD_RATE_SCALE_LOW_LSB +: 2]};
    estimator_mode_field = fbd_est_mode_type'(est_ctrl_q[FBD_EST_MODE_LSB +: 2]);
    estimator_length_field = est_ctrl_q[FBD_EST_LENGTH_LSB +: 2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers; constant bits are kept as the host writes them, except estimator control bits 7:4, which are cleared
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      main_q <= FBD_REG_RESET;
      filter_q <= FBD_REG_RESET;
      sync_scale_q <= FBD_REG_RESET;
      rate_ref_q <= FBD_REG_RESET;
      est_ctrl_q <= FBD_REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == FBD_MAIN_CONTROL) begin
        main_q <= reg_wdata;
      end else if (reg_addr == FBD_SIGNAL_FILTER_CONTROL) begin
        filter_q <= reg_wdata;
      end else if (reg_addr == FBD_SYNC_CLOCK_SCALE) begin
        sync_scale_q <= reg_wdata;
      end else if (reg_addr == FBD_RATE_SCALE_AND_REF_DIVIDER) begin
        rate_ref_q <= reg_wdata;
      end else if (reg_addr == FBD_ERROR_ESTIMATOR_CONTROL) begin
        est_ctrl_q <= reg_wdata & FBD_ESTIMATOR_CTRL_MASK;
      end
    end
  end

  // read mux, registered; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= FBD_REG_RESET;
    end else if (reg_addr == FBD_MAIN_CONTROL) begin
      reg_rdata <= main_q;
    end else if (reg_addr == FBD_SIGNAL_FILTER_CONTROL) begin
      reg_rdata <= filter_q;
    end else if (reg_addr == FBD_SYNC_CLOCK_SCALE) begin
      reg_rdata <= sync_scale_q;
    end else if (reg_addr == FBD_RATE_SCALE_AND_REF_DIVIDER) begin
      reg_rdata <= rate_ref_q;
    end else if (reg_addr == FBD_ERROR_ESTIMATOR_CONTROL) begin
      reg_rdata <= est_ctrl_q;
    end else if (reg_addr == FBD_ERROR_ESTIMATOR_RESULT) begin
      reg_rdata <= result_q; // RULE5
    end else begin
      reg_rdata <= FBD_REG_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived clocks: one k register feeds both dividers
  fbd_rate_div u_rate_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(is_tx && sync_en),
    .ref_div(ref_div), // RULE16
    .scale(symbol_rate_clock_scale),
    .tick(rate_tick),
    .half_tick(rate_half)
  );

  fbd_rate_div u_sync_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(!is_tx),
    .ref_div(ref_div), // RULE16
    .scale(resync_clock_scale),
    .tick(os_tick),
    .half_tick()
  );

  ////////////////////////////////////////////////////////////////////////////
  // bit synchronizer: 16 phases per bit, nudged one phase per data edge
  always_comb begin
    bit_edge = os_tick && (demod_bit != bit_prev_q);
    bit_center = os_tick && (phase_q == FBD_PHASE_MID);
    bit_clk_fall = os_tick && (phase_q == '0);
  end

  // an edge early in the bit holds the phase, late skips one; eight edges
  // cover the worst half-bit offset, well inside 22 bits of preamble;
  // an edge at the last phase is left alone so the clock fall is never skipped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '0;
      bit_prev_q <= 1'b0;
    end else if (is_tx) begin
      phase_q <= '0;
      bit_prev_q <= demod_bit;
    end else if (os_tick) begin
      bit_prev_q <= demod_bit;
      if (bit_edge && (phase_q != '0) && (phase_q < FBD_PHASE_MID)) begin
        phase_q <= phase_q; // RULE17
      end else if (bit_edge && (phase_q >= FBD_PHASE_MID) && (phase_q != FBD_PHASE_TOP)) begin
        phase_q <= phase_q + FBD_PHASE_TWO; // RULE17
      end else begin
        phase_q <= phase_q + FBD_PHASE_ONE;
      end
    end
  end

  // lock when edges land next to the bit boundary
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync_locked <= 1'b0;
    end else if (is_tx || !sync_en) begin
      sync_locked <= 1'b0;
    end else if (bit_edge) begin
      sync_locked <= (phase_q <= FBD_PHASE_ONE) || (phase_q == FBD_PHASE_TOP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pin: output in receive, input in transmit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      data_io_pin_out <= 1'b0;
      data_io_pin_oe_n <= 1'b1;
    end else begin
      data_io_pin_oe_n <= is_tx; // RULE22
      if (is_tx) begin
        data_io_pin_out <= 1'b0;
      end else if (!sync_en) begin
        data_io_pin_out <= demod_bit; // RULE10
      end else if (bit_center) begin
        data_io_pin_out <= demod_bit; // RULE12
      end
    end
  end

  // data clock pin: recovered clock in receive, bit-rate clock in transmit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      data_clock_pin_out <= 1'b0;
      data_clock_pin_oe_n <= 1'b1;
    end else begin
      data_clock_pin_oe_n <= !sync_en;
      if (!sync_en) begin
        data_clock_pin_out <= 1'b0;
      end else if (is_tx) begin
        if (rate_tick) begin
          data_clock_pin_out <= 1'b1; // RULE23
        end else if (rate_half) begin
          data_clock_pin_out <= 1'b0;
        end
      end else if (bit_center) begin
        data_clock_pin_out <= 1'b1; // RULE11
      end else if (bit_clk_fall) begin
        data_clock_pin_out <= 1'b0; // RULE11
      end
    end
  end

  // divider set follows the transmit bit; sampled on clock rise when synchronous
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tone_divider_set <= 1'b0;
    end else if (is_tx && (!sync_en || rate_tick)) begin
      tone_divider_set <= data_io_pin_in; // RULE21 RULE23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit power: level always scales, zero level shuts the amplifier
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      output_power_level <= FBD_POWER_OFF;
      pa_enable <= 1'b0;
      pa_bypass <= 1'b0;
    end else begin
      output_power_level <= main_q[FBD_POWER_LSB +: 3]; // RULE18 RULE20
      pa_enable <= (main_q[FBD_POWER_LSB +: 3] != FBD_POWER_OFF); // RULE18 RULE19
      pa_bypass <= amplifier_bypass; // RULE20
    end
  end

  // receive front-end controls straight from their registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      front_amp_bypass <= 1'b0;
      signal_strength_enable <= 1'b0;
      lock_detect_enable <= 1'b0;
      prefilter_cutoff <= 2'h0;
    end else begin
      front_amp_bypass <= main_q[FBD_FRONT_AMP_BYPASS_BIT];
      signal_strength_enable <= filter_q[FBD_SIG_STRENGTH_BIT];
      lock_detect_enable <= filter_q[FBD_LOCK_DETECT_BIT];
      prefilter_cutoff <= filter_q[FBD_PREFILTER_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error estimator; demodulator gives about 2x modulation index pulses per symbol // RULE2
  always_comb begin
    est_start = reg_wr && (reg_addr == FBD_ERROR_ESTIMATOR_CONTROL)
                && (reg_wdata[FBD_EST_MODE_LSB +: 2] != FBD_EST_OFF);
    case (estimator_length_field)
      2'b00: sym_len = FBD_LEN_8; // RULE4
      2'b01: sym_len = FBD_LEN_16;
      2'b10: sym_len = FBD_LEN_32;
      default: sym_len = FBD_LEN_64; // RULE4
    endcase
    step = FBD_STEP_NONE;
    case (estimator_mode_field)
      FBD_EST_UP: step = demod_up ? FBD_STEP_UP : FBD_STEP_NONE; // RULE1 RULE3
      FBD_EST_DN: step = demod_dn ? FBD_STEP_DN : FBD_STEP_NONE; // RULE3 RULE6
      FBD_EST_UPDN: begin
        if (demod_up && !demod_dn) begin
          step = FBD_STEP_UP; // RULE3
        end else if (demod_dn && !demod_up) begin
          step = FBD_STEP_DN; // RULE3
        end
      end
      default: step = FBD_STEP_NONE;
    endcase
    cnt_d = cnt_q + step; // RULE7
    sym_end = (fee_q == FBD_FEE_RUN) && bit_center && (sym_q == sym_len - 7'h01);
  end

  // measurement state; a nonzero mode write restarts from zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fee_q <= FBD_FEE_IDLE;
      cnt_q <= '0;
      sym_q <= '0;
    end else if (est_start) begin
      fee_q <= FBD_FEE_RUN; // RULE24
      cnt_q <= '0;
      sym_q <= '0;
    end else if (estimator_mode_field == FBD_EST_OFF || is_tx) begin
      fee_q <= FBD_FEE_IDLE;
    end else if (fee_q == FBD_FEE_RUN) begin
      cnt_q <= sym_end ? 8'h00 : cnt_d;
      if (sym_end) begin
        sym_q <= '0;
      end else if (bit_center) begin
        sym_q <= sym_q + 7'h01;
      end
    end
  end

  // result updates only at the end of each measurement
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= '0;
    end else if (!est_start && sym_end && estimator_mode_field != FBD_EST_OFF && !is_tx) begin
      result_q <= cnt_d; // RULE5 RULE24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_mid_measure;
    fee_q == FBD_FEE_RUN && !sym_end && !est_start && !is_tx;
  endsequence

  chk_up_count_step : assert property ( // RULE1
    s_mid_measure and (estimator_mode_field == FBD_EST_UP && demod_up && $stable(est_ctrl_q))
    |=> cnt_q == $past(cnt_q) + FBD_STEP_UP)
    else $error("up pulse not counted");

  chk_dn_count_step : assert property ( // RULE3
    s_mid_measure and (estimator_mode_field == FBD_EST_DN && demod_dn && $stable(est_ctrl_q))
    |=> cnt_q == $past(cnt_q) + FBD_STEP_DN)
    else $error("down pulse not counted");

  chk_start_clears : assert property ( // RULE24
    est_start |=> fee_q == FBD_FEE_RUN && cnt_q == '0 && sym_q == '0)
    else $error("new measurement not cleared");

  chk_result_load : assert property ( // RULE5
    sym_end && !est_start && estimator_mode_field != FBD_EST_OFF && !is_tx
    |=> result_q == $past(cnt_d) && cnt_q == '0)
    else $error("result not loaded at end");

  chk_pa_off_zero : assert property ( // RULE19
    pa_enable == (output_power_level != FBD_POWER_OFF))
    else $error("amplifier enable disagrees with level");

  chk_data_pin_dir : assert property ( // RULE22
    $stable(main_q) && is_tx |=> data_io_pin_oe_n)
    else $error("data pin driven in transmit");

  chk_tx_divider : assert property ( // RULE21
    is_tx && !sync_en |=> tone_divider_set == $past(data_io_pin_in))
    else $error("divider set not following data");

  chk_rx_data_fall : assert property ( // RULE12
    !is_tx && sync_en && $fell(data_clock_pin_out) && $past(sync_en) && $past(!is_tx)
    |-> $stable(data_io_pin_out))
    else $error("received data changed off clock rise");

endmodule : fbd_core

`default_nettype wire

// ===== sim/fbd_host_model.sv
// Purpose: host controller model on the data and data clock pins
// Assumes: pin levels are resolved by the bench
// Notes: acts only on data clock falls, so device edges are never raced
`timescale 1ns/100ps
`default_nettype none

module fbd_host_model (
  input wire logic ref_clk,        // bench clock
  input wire logic clk_pin,        // data clock pin level
  input wire logic data_pin,       // data pin level
  input wire logic dev_drives,     // device owns the data pin
  input wire logic [15:0] tx_pat,  // bits to send, msb first
  output logic host_data,          // host drive for the data pin
  output logic [15:0] rx_bits      // last sixteen bits taken
);
  logic clk_prev = 1'b0;
  logic [3:0] idx = 4'hf;

  initial begin
    host_data = 1'b0;
    rx_bits = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // on a clock fall: take a received bit, or present the next transmit bit
  always @(posedge ref_clk) begin
    clk_prev <= clk_pin;
    if (clk_prev && !clk_pin) begin
      if (dev_drives) begin
        rx_bits <= {rx_bits[14:0], data_pin};
      end else begin
        host_data <= tx_pat[idx];
        idx <= idx - 4'h1;
      end
    end
  end
endmodule : fbd_host_model

`default_nettype wire

// ===== sim/fbd_core_bench.sv
// Purpose: self-checking bench for fbd_core
// Assumes: k=1, resync scale 7 (one oversample tick a cycle), rate scale 3
// Notes: expectations come from the register map and counting rules
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); \
  end \
end

module fbd_core_bench;
  import fbd_pkg::*;
  logic ref_clk, nrst, reg_wr, demod_up, demod_dn, demod_bit, amplifier_bypass;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic d_out, d_oe_n, c_out, c_oe_n, tone, pa_en, pa_byp, fab, sse, lde, locked;
  logic [2:0] power;
  logic [1:0] pf;
  logic host_data, pin, d_prev, c_prev, p_prev;
  logic rx_mon = 1'b0;
  logic tx_mon = 1'b0;
  logic tx_flip = 1'b0;
  logic [15:0] rx_bits;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int rises = 0;

  // the data pin carries whichever side currently drives it
  assign pin = d_oe_n ? (host_data ^ tx_flip) : d_out;

  fbd_core dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .demod_up(demod_up),
    .demod_dn(demod_dn), .demod_bit(demod_bit), .amplifier_bypass(amplifier_bypass),
    .data_io_pin_in(pin), .data_io_pin_out(d_out), .data_io_pin_oe_n(d_oe_n),
    .data_clock_pin_out(c_out), .data_clock_pin_oe_n(c_oe_n), .tone_divider_set(tone),
    .output_power_level(power), .pa_enable(pa_en), .pa_bypass(pa_byp),
    .front_amp_bypass(fab), .signal_strength_enable(sse), .lock_detect_enable(lde),
    .prefilter_cutoff(pf), .sync_locked(locked));

  fbd_host_model host (.ref_clk(ref_clk), .clk_pin(c_out & ~c_oe_n), .data_pin(pin),
    .dev_drives(~d_oe_n), .tx_pat(16'hb38e), .host_data(host_data), .rx_bits(rx_bits));

  ////////////////////////////////////////////////////////////////////////////
  // clock and a cycle ceiling well above the roughly 3500 cycles needed
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  // pin monitor: data moves only at clock rises, tone follows the pin there
  always @(posedge ref_clk) begin
    if (rx_mon && d_out !== d_prev) `CHK("rx data at rise", 1'b1, c_out & ~c_prev)
    if (tx_mon && c_out && !c_prev) `CHK("tone set", p_prev, tone)
    if (c_out && !c_prev) rises++;
    d_prev <= d_out;
    c_prev <= c_out;
    p_prev <= pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(nm, e, reg_rdata)
  endtask : rd_chk

  // one measurement: pulses early, result unchanged before the end, new after
  task automatic est(input logic [3:0] ctl, input int nu, input int nd, input int len,
                     input logic [7:0] prev, input logic [7:0] e);
    int n;
    n = (nu > nd) ? nu : nd;
    wr(FBD_ERROR_ESTIMATOR_CONTROL, {4'h0, ctl});
    for (int i = 0; i < n; i++) begin
      demod_up = (i < nu);
      demod_dn = (i < nd);
      @(posedge ref_clk);
      #1;
    end
    demod_up = 1'b0;
    demod_dn = 1'b0;
    repeat (len * 16 - 26 - n) @(posedge ref_clk);
    rd_chk(FBD_ERROR_ESTIMATOR_RESULT, prev, "result before end");
    repeat (40) @(posedge ref_clk);
    rd_chk(FBD_ERROR_ESTIMATOR_RESULT, e, "result");
    wr(FBD_ERROR_ESTIMATOR_CONTROL, 8'h00);
  endtask : est

  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    demod_up = 1'b0;
    demod_dn = 1'b0;
    demod_bit = 1'b0;
    amplifier_bypass = 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK("reset pin release", 1'b1, d_oe_n)
    #1;
    nrst = 1'b1;
    for (int l = 0; l < 8; l++) begin
      amplifier_bypass = l[0];
      wr(FBD_MAIN_CONTROL, {l[0], l[2:0], 4'h1});
      @(posedge ref_clk);
      #1;
      `CHK("power level", l[2:0], power)
      `CHK("pa enable", l != 0, pa_en)
      `CHK("pa bypass", l[0], pa_byp)
      `CHK("front bypass", l[0], fab)
    end
    wr(FBD_SIGNAL_FILTER_CONTROL, 8'h8d);
    rd_chk(FBD_SIGNAL_FILTER_CONTROL, 8'h8d, "filter reg");
    `CHK("filter outs", 4'hd, {sse, lde, pf})
    wr(FBD_ERROR_ESTIMATOR_CONTROL, 8'hf0);
    rd_chk(FBD_ERROR_ESTIMATOR_CONTROL, 8'h00, "est ctrl");
    wr(FBD_ERROR_ESTIMATOR_RESULT, 8'h55);
    rd_chk(FBD_ERROR_ESTIMATOR_RESULT, 8'h00, "result read only");
    wr(7'h20, 8'haa);
    rd_chk(7'h20, 8'h00, "unmapped");
    wr(FBD_SYNC_CLOCK_SCALE, 8'h0e);
    wr(FBD_RATE_SCALE_AND_REF_DIVIDER, 8'hc1);
    rd_chk(FBD_RATE_SCALE_AND_REF_DIVIDER, 8'hc1, "ref divider");
    est(4'h1, 5, 3, 8, 8'h00, 8'h05);
    est(4'h6, 5, 3, 16, 8'h05, 8'hfd);
    est(4'hb, 5, 3, 32, 8'hfd, 8'h02);
    est(4'hf, 0, 130, 64, 8'h02, 8'h7e);
    est(4'h0, 5, 0, 8, 8'h7e, 8'h7e);
    wr(FBD_MAIN_CONTROL, 8'h01);
    for (int b = 0; b < 2; b++) begin
      demod_bit = b[0];
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK("plain rx data", b[0], d_out)
    end
    `CHK("rx pin drive", 1'b0, d_oe_n)
    wr(FBD_MAIN_CONTROL, 8'h09);
    rx_mon = 1'b1;
    for (int b = 0; b < 40; b++) begin
      demod_bit = b[0];
      if (b == 24) rises = 0;
      repeat (16) @(posedge ref_clk);
      #1;
    end
    `CHK("rx clock count", 16, rises)
    `CHK("rx bits", 1'b1, rx_bits === 16'haaaa || rx_bits === 16'h5555)
    `CHK("locked", 1'b1, locked)
    rx_mon = 1'b0;
    wr(FBD_MAIN_CONTROL, 8'h0d);
    @(posedge ref_clk);
    #1;
    `CHK("tx pin released", 1'b1, d_oe_n)
    `CHK("tx clock driven", 1'b0, c_oe_n)
    tx_mon = 1'b1;
    rises = 0;
    repeat (640) @(posedge ref_clk);
    #1;
    `CHK("tx clock count", 40, rises)
    // transparent transmit: the divider set follows the pin every cycle
    wr(FBD_MAIN_CONTROL, 8'h05);
    for (int b = 0; b < 4; b++) begin
      tx_flip = b[0];
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("plain tx tone", pin, tone)
    end
    results();
  end
endmodule : fbd_core_bench

`default_nettype wire
